// ---- hdl/ivm_pkg.sv ----
// Purpose: constants for the interrupt vector address map
// Assumes: 20-bit byte address space, 4-byte vector slots
// Notes: fixed slots sit at the top of memory, table entries are relocatable
package ivm_pkg;
    localparam int ADDR_W = 20;
    localparam logic [19:0] FIX_BASE = 20'hfffdc;
    localparam logic [19:0] FIX_UNDEF = 20'hfffdc;
    localparam logic [19:0] FIX_OVF = 20'hfffe0;
    localparam logic [19:0] FIX_BREAK = 20'hfffe4;
    localparam logic [19:0] FIX_ADDR_MATCH = 20'hfffe8;
    localparam logic [19:0] FIX_SSTEP = 20'hfffec;
    localparam logic [19:0] FIX_SYSMON = 20'hffff0;
    localparam logic [19:0] FIX_DEBUG = 20'hffff4;
    localparam logic [19:0] FIX_NMI = 20'hffff8;
    localparam logic [19:0] FIX_RESET = 20'hffffc;
    localparam logic [19:0] FIX_TOP = 20'hfffff;
    localparam logic [7:0] BREAK_REDIRECT = 8'hff;
    localparam logic [3:0] RESET_RSV = 4'hf;
    localparam logic [8:0] TABLE_SIZE = 9'h100;
    localparam logic [5:0] SLOT_SHARED_A = 6'h08;
    localparam logic [5:0] SLOT_SHARED_B = 6'h09;
    localparam logic [5:0] SLOT_COLLIDE = 6'h0a;
    localparam logic [5:0] SLOT_TX2 = 6'h0f;
    localparam logic [5:0] SLOT_RX2 = 6'h10;
    localparam logic [5:0] SLOT_SW_FIRST = 6'h20;
    localparam logic [3:0] N_FIXED = 4'h9;
    localparam logic [2:0] WORDS_EVEN = 3'h2;
    localparam logic [2:0] WORDS_ODD = 3'h4;
    typedef enum logic [3:0] {
        IVM_SRC_UNDEF, IVM_SRC_OVF, IVM_SRC_BREAK, IVM_SRC_ADDR_MATCH,
        IVM_SRC_SSTEP, IVM_SRC_SYSMON, IVM_SRC_DEBUG, IVM_SRC_NMI,
        IVM_SRC_RESET, IVM_SRC_TABLE
    } ivm_src_t;
endpackage

// ---- hdl/ivm_fix_rom.sv ----
// Purpose: small memory for the fixed vector slots, registered read
// Assumes: one byte per entry, nine slots of four bytes
// Notes: written by the loader port, read by the fetch engine
`timescale 1ns/100ps
module ivm_fix_rom (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [5:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [5:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:35];

    // write port and registered read; contents hold no reset value
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= 8'h00;
        end
        else
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ---- hdl/ivm_vector_map.sv ----
// Purpose: turns an accepted interrupt into a vector fetch and handler jump
// Assumes: sequencer gives source and number, then waits for done
// Notes: table fetches are two 16-bit words when base is even, four bytes when odd
`timescale 1ns/100ps
module ivm_vector_map (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic accept,
    input wire ivm_pkg::ivm_src_t src,
    input wire logic [5:0] irq_number,
    input wire logic [19:0] vector_table_base,
    input wire logic [1:0] irq_source_select_reg,
    input wire logic two_wire_mode,
    input wire logic global_irq_enable,
    input wire logic fix_wr_en,
    input wire logic [5:0] fix_wr_addr,
    input wire logic [7:0] fix_wr_data,
    input wire logic ext_pin_request_a,
    input wire logic ext_pin_request_b,
    input wire logic ext_pin_request_c,
    input wire logic serial2_tx_irq,
    input wire logic serial2_rx_irq,
    input wire logic serial2_not_ack_event,
    input wire logic serial2_ack_event,
    input wire logic serial2_collision,
    input wire logic serial2_start_stop,
    input wire logic watchdog_irq,
    input wire logic osc_stop_irq,
    input wire logic supply_drop_irq,
    input wire logic [15:0] mem_rdata,
    output logic mem_rd,
    output logic [19:0] mem_addr,
    output logic busy,
    output logic done,
    output logic [19:0] handler_addr,
    output logic [19:0] vector_addr,
    output logic maskable,
    output logic blocked,
    output logic slot8_req,
    output logic slot9_req,
    output logic slot10_req,
    output logic slot15_req,
    output logic slot16_req,
    output logic sysmon_req,
    output logic [7:0] id_check_byte,
    output logic [5:0] id_check_idx,
    output logic reset_rsv_ok
);
    typedef enum logic [2:0] {
        IVM_IDLE, IVM_BREAK_CHK, IVM_FIX_RD, IVM_TAB_RD, IVM_DONE
    } ivm_state_t;

    typedef struct packed {
        ivm_state_t st;
        logic [19:0] vaddr;
        logic [23:0] acc;
        logic [2:0] cnt;
        logic [5:0] ridx;
        logic sdone;
        logic [19:0] hnd;
        logic rsv_ok;
        logic [3:0] idf;
        logic s8;
        logic s9;
        logic s10;
        logic s15;
        logic s16;
        logic smon;
    } ivm_regs_t;

    ivm_regs_t r;
    ivm_regs_t next_r;
    logic [7:0] rom_q;
    logic [19:0] tab_addr;
    logic is_sw_nonmask;

    ////////////////////////////////////////////////////////////////////////
    // fixed slot memory
    ivm_fix_rom u_rom (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(fix_wr_en),
        .wr_addr(fix_wr_addr),
        .wr_data(fix_wr_data),
        .rd_addr(r.ridx),
        .rd_data(rom_q)
    );

    // byte index of a fixed slot: four bytes each from the lowest slot
    function automatic logic [5:0] fix_idx(input ivm_pkg::ivm_src_t s);
        logic [19:0] a;
        a = 20'h0;
        case (s)
            ivm_pkg::IVM_SRC_UNDEF: a = ivm_pkg::FIX_UNDEF;
            ivm_pkg::IVM_SRC_OVF: a = ivm_pkg::FIX_OVF;
            ivm_pkg::IVM_SRC_BREAK: a = ivm_pkg::FIX_BREAK;
            ivm_pkg::IVM_SRC_ADDR_MATCH: a = ivm_pkg::FIX_ADDR_MATCH;
            ivm_pkg::IVM_SRC_SSTEP: a = ivm_pkg::FIX_SSTEP;
            ivm_pkg::IVM_SRC_SYSMON: a = ivm_pkg::FIX_SYSMON;
            ivm_pkg::IVM_SRC_DEBUG: a = ivm_pkg::FIX_DEBUG;
            ivm_pkg::IVM_SRC_NMI: a = ivm_pkg::FIX_NMI;
            default: a = ivm_pkg::FIX_RESET;
        endcase
        fix_idx = 6'((a - ivm_pkg::FIX_BASE));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // table entry address, entry n at base plus four times n
    assign tab_addr = vector_table_base + {12'h000, irq_number, 2'b00};
    assign is_sw_nonmask = (src == ivm_pkg::IVM_SRC_BREAK) ||
        (src == ivm_pkg::IVM_SRC_TABLE &&
         irq_number >= ivm_pkg::SLOT_SW_FIRST);

    // request masking: maskable table entries and the global enable
    always_comb
    begin
        maskable = (src == ivm_pkg::IVM_SRC_TABLE) && !is_sw_nonmask;
        blocked = maskable && !global_irq_enable;
    end

    // state update
    always_comb
    begin
        next_r = r;
        next_r.sdone = 1'b0;
        // shared entries: pin select and two-wire mode steer the source
        next_r.s8 = irq_source_select_reg[0] ? ext_pin_request_c
                                             : ext_pin_request_a;
        next_r.s9 = irq_source_select_reg[1] ? ext_pin_request_c
                                             : ext_pin_request_b;
        next_r.s10 = two_wire_mode ? serial2_start_stop
                                   : serial2_collision;
        next_r.s15 = two_wire_mode ? serial2_not_ack_event
                                   : serial2_tx_irq;
        next_r.s16 = two_wire_mode ? serial2_ack_event
                                   : serial2_rx_irq;
        next_r.smon = watchdog_irq | osc_stop_irq | supply_drop_irq;
        // identity check walks the upper byte of each fixed slot
        next_r.idf = (r.idf == ivm_pkg::N_FIXED - 4'h1) ? 4'h0 : r.idf + 4'h1;
        case (r.st)
            IVM_IDLE:
            begin
                next_r.ridx = {r.idf[3:0], 2'b11};
                if (accept && !blocked)
                begin
                    next_r.cnt = 3'h0;
                    next_r.acc = 24'h0;
                    if (src == ivm_pkg::IVM_SRC_TABLE)
                    begin
                        next_r.vaddr = tab_addr;
                        next_r.st = IVM_TAB_RD;
                    end
                    else if (src == ivm_pkg::IVM_SRC_BREAK)
                    begin
                        next_r.vaddr = ivm_pkg::FIX_BREAK;
                        next_r.ridx = fix_idx(src) + 6'h3;
                        next_r.st = IVM_BREAK_CHK;
                    end
                    else
                    begin
                        next_r.vaddr = ivm_pkg::FIX_BASE + 20'(fix_idx(src));
                        next_r.ridx = fix_idx(src);
                        next_r.st = IVM_FIX_RD;
                    end
                end
            end
            IVM_BREAK_CHK:
            begin
                next_r.cnt = r.cnt + 3'h1;
                if (r.cnt == 3'h1)
                begin
                    next_r.cnt = 3'h0;
                    if (rom_q == ivm_pkg::BREAK_REDIRECT)
                    begin
                        next_r.vaddr = vector_table_base;
                        next_r.st = IVM_TAB_RD;
                    end
                    else
                    begin
                        // the source input may have moved on since the take
                        next_r.ridx = fix_idx(ivm_pkg::IVM_SRC_BREAK);
                        next_r.st = IVM_FIX_RD;
                    end
                end
            end
            IVM_FIX_RD:
            begin
                // one byte per cycle, read data lags the index by one
                next_r.cnt = r.cnt + 3'h1;
                next_r.ridx = r.ridx + 6'h1;
                if (r.cnt != 3'h0)
                begin
                    next_r.acc = {rom_q, r.acc[23:8]};
                end
                // last byte of the slot is on the read port at count four
                if (r.cnt == 3'h4 && r.vaddr == ivm_pkg::FIX_RESET)
                begin
                    next_r.rsv_ok = (rom_q[3:0] == ivm_pkg::RESET_RSV);
                end
                if (r.cnt == 3'h4)
                begin
                    next_r.hnd = r.acc[19:0];
                    next_r.st = IVM_DONE;
                end
            end
            IVM_TAB_RD:
            begin
                // even base: two word reads; odd base: four byte reads
                next_r.cnt = r.cnt + 3'h1;
                if (r.vaddr[0] == 1'b0)
                begin
                    next_r.acc = {mem_rdata, r.acc[23:16]};
                end
                else
                begin
                    next_r.acc = {mem_rdata[7:0], r.acc[23:8]};
                end
                if (r.cnt == (r.vaddr[0] ? ivm_pkg::WORDS_ODD
                                         : ivm_pkg::WORDS_EVEN) - 3'h1)
                begin
                    next_r.hnd = r.vaddr[0] ?
                        r.acc[19:0] :
                        {mem_rdata[3:0], r.acc[23:8]};
                    next_r.st = IVM_DONE;
                end
            end
            default:
            begin
                next_r.sdone = 1'b1;
                next_r.st = IVM_IDLE;
            end
        endcase
    end

    // one register bank for all state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign mem_rd = (r.st == IVM_TAB_RD);
    assign mem_addr = r.vaddr + (r.vaddr[0] ? 20'(r.cnt)
                                            : 20'({r.cnt[1:0], 1'b0}));
    assign busy = (r.st != IVM_IDLE);
    assign done = r.sdone;
    assign handler_addr = r.hnd;
    assign vector_addr = r.vaddr;
    assign slot8_req = r.s8;
    assign slot9_req = r.s9;
    assign slot10_req = r.s10;
    assign slot15_req = r.s15;
    assign slot16_req = r.s16;
    assign sysmon_req = r.smon;
    assign id_check_byte = rom_q;
    assign id_check_idx = r.ridx;
    assign reset_rsv_ok = r.rsv_ok;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_tab_even;
        !busy && accept && !blocked && src == ivm_pkg::IVM_SRC_TABLE &&
            !tab_addr[0];
    endsequence

    property p_even_fast;
        @(posedge clk_sys) disable iff (!rst_n)
        s_tab_even |=> mem_rd [*2] ##1 !mem_rd ##1 done;
    endproperty
    a_even_fast: assert property (p_even_fast)
        else $error("even base fetch not two words");

    property p_tab_addr;
        @(posedge clk_sys) disable iff (!rst_n)
        s_tab_even |=> vector_addr ==
            $past(vector_table_base) + {12'h000, $past(irq_number), 2'b00};
    endproperty
    a_tab_addr: assert property (p_tab_addr)
        else $error("table entry address wrong");

    property p_block;
        @(posedge clk_sys) disable iff (!rst_n)
        accept && blocked && !busy |=> !busy;
    endproperty
    a_block: assert property (p_block)
        else $error("masked request started a fetch");

    property p_swnm;
        @(posedge clk_sys) disable iff (!rst_n)
        src == ivm_pkg::IVM_SRC_TABLE && irq_number >= 6'h20 |-> !blocked;
    endproperty
    a_swnm: assert property (p_swnm)
        else $error("software entry blocked by enable");

    property p_undef;
        @(posedge clk_sys) disable iff (!rst_n)
        !busy && accept && src == ivm_pkg::IVM_SRC_UNDEF
            |=> vector_addr == 20'hfffdc;
    endproperty
    a_undef: assert property (p_undef)
        else $error("undefined opcode slot wrong");

    property p_ovf;
        @(posedge clk_sys) disable iff (!rst_n)
        !busy && accept && src == ivm_pkg::IVM_SRC_OVF
            |=> vector_addr == 20'hfffe0;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow slot wrong");

    property p_s15;
        @(posedge clk_sys) disable iff (!rst_n)
        two_wire_mode |=> slot15_req == $past(serial2_not_ack_event);
    endproperty
    a_s15: assert property (p_s15)
        else $error("entry 15 source wrong");

    property p_s10;
        @(posedge clk_sys) disable iff (!rst_n)
        !two_wire_mode |=> slot10_req == $past(serial2_collision);
    endproperty
    a_s10: assert property (p_s10)
        else $error("entry 10 source wrong");

    property p_fix_done;
        @(posedge clk_sys) disable iff (!rst_n)
        !busy && accept && src == ivm_pkg::IVM_SRC_NMI |-> ##7 done;
    endproperty
    a_fix_done: assert property (p_fix_done)
        else $error("fixed fetch did not finish in time");
endmodule

// ---- bench/ivm_table_mem.sv ----
// Purpose: core-side table memory that answers the vector fetch reads
// Assumes: combinational answer to mem_addr in the cycle mem_rd is high
// Notes: byte contents follow a keyed formula so the bench can predict them
`timescale 1ns/100ps
module ivm_table_mem (
    input wire logic clk_sys,
    input wire logic mem_rd,
    input wire logic [19:0] mem_addr,
    input wire logic [7:0] key,
    output logic [15:0] mem_rdata
);
    logic [15:0] last;
    logic [15:0] live;

    ////////////////////////////////////////////////////////////////////////
    // little endian word of two bytes from the keyed formula
    always_comb
    begin
        live[7:0] = mem_addr[7:0] ^ {mem_addr[11:8], mem_addr[19:16]} ^ key;
        live[15:8] = (mem_addr[7:0] + 8'h01) ^
            {mem_addr[11:8], mem_addr[19:16]} ^ key;
    end

    // remember the last answer so an idle bus never repeats it
    always_ff @(posedge clk_sys)
    begin
        if (mem_rd)
            last <= live;
    end

    // released bus shows the inverse, not a stale value the fetch could use
    assign mem_rdata = mem_rd ? live : ~last;
endmodule

// ---- bench/ivm_vector_map_tb_top.sv ----
// Purpose: self-checking bench for the vector address map
// Assumes: one 25 MHz clock, table memory model on the fetch port
// Notes: expected slots and handlers are rebuilt from the memory layout
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
        end \
    end
module ivm_vector_map_tb_top;
    logic clk_sys = 1'b0, rst_n = 1'b0, accept = 1'b0;
    ivm_pkg::ivm_src_t src = ivm_pkg::IVM_SRC_TABLE;
    logic [5:0] irq_number = 6'h00, fa = 6'h00;
    logic [19:0] base = 20'h00000;
    logic [1:0] sel = 2'h0;
    logic tw = 1'b0, gie = 1'b1, fwe = 1'b0;
    logic [7:0] fd = 8'h00, key = 8'h00;
    logic [2:0] pin = 3'h0;
    logic [5:0] ser = 6'h00;
    logic [2:0] mon = 3'h0;
    logic [15:0] mem_rdata;
    logic mem_rd, busy, done, maskable, blocked, rsv_ok;
    logic [19:0] mem_addr, handler_addr, vector_addr;
    logic [5:0] slots, id_idx;
    logic [7:0] id_byte;
    logic [7:0] fixb [0:35];
    int checks = 0, failures = 0, cycles = 0;

    ivm_vector_map i_ivm_vector_map (.clk_sys(clk_sys), .rst_n(rst_n),
        .accept(accept), .src(src), .irq_number(irq_number),
        .vector_table_base(base), .irq_source_select_reg(sel),
        .two_wire_mode(tw), .global_irq_enable(gie), .fix_wr_en(fwe),
        .fix_wr_addr(fa), .fix_wr_data(fd), .ext_pin_request_a(pin[0]),
        .ext_pin_request_b(pin[1]), .ext_pin_request_c(pin[2]),
        .serial2_tx_irq(ser[0]), .serial2_rx_irq(ser[1]),
        .serial2_not_ack_event(ser[2]), .serial2_ack_event(ser[3]),
        .serial2_collision(ser[4]), .serial2_start_stop(ser[5]),
        .watchdog_irq(mon[0]), .osc_stop_irq(mon[1]),
        .supply_drop_irq(mon[2]), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .busy(busy), .done(done),
        .handler_addr(handler_addr), .vector_addr(vector_addr),
        .maskable(maskable), .blocked(blocked), .slot8_req(slots[0]),
        .slot9_req(slots[1]), .slot10_req(slots[2]), .slot15_req(slots[3]),
        .slot16_req(slots[4]), .sysmon_req(slots[5]),
        .id_check_byte(id_byte), .id_check_idx(id_idx),
        .reset_rsv_ok(rsv_ok));

    ivm_table_mem i_ivm_table_mem (.clk_sys(clk_sys), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .key(key), .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reference model of table bytes and slot contents
    function automatic logic [7:0] mb(input logic [19:0] a);
        return a[7:0] ^ {a[11:8], a[19:16]} ^ key;
    endfunction

    function automatic logic [19:0] tab(input logic [19:0] v);
        logic [7:0] b2;
        b2 = mb(v + 20'h00002);
        return {b2[3:0], mb(v + 20'h00001), mb(v)};
    endfunction

    function automatic logic [19:0] fixh(input int i);
        return {fixb[i+2][3:0], fixb[i+1], fixb[i]};
    endfunction

    task automatic wfix(input int i, input logic [7:0] d);
        @(negedge clk_sys);
        fixb[i] = d;
        fwe = 1'b1;
        fa = 6'(i);
        fd = d;
        @(negedge clk_sys);
        fwe = 1'b0;
    endtask

    // one accepted fetch, latency counted from the taking edge
    task automatic run(input ivm_pkg::ivm_src_t s, input logic [5:0] n,
        input int lat, input logic [19:0] va, input logic [19:0] ha);
        int k;
        @(negedge clk_sys);
        accept = 1'b1;
        src = s;
        irq_number = n;
        @(negedge clk_sys);
        accept = 1'b0;
        `CHK(busy, 1'b1)
        k = 1;
        while (done !== 1'b1 && k < 20)
        begin
            @(negedge clk_sys);
            k++;
        end
        `CHK(k, lat)
        `CHK(busy, 1'b0)
        `CHK(vector_addr, va)
        `CHK(handler_addr, ha)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        int n, lat, p;
        void'($urandom(42));
        key = 8'($urandom);
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        // fixed slots loaded; reserved reset nibble all ones, no redirect
        for (int i = 0; i < 36; i++)
            wfix(i, (i == 35) ? (8'($urandom) | 8'h0f) :
                ((i == 11) ? 8'h00 : 8'($urandom)));
        for (int s = 0; s < 9; s++)
            run(ivm_pkg::ivm_src_t'(s), 6'h00, (s == 2) ? 9 : 7,
                20'hfffdc + 20'(4 * s), fixh(4 * s));
        `CHK(rsv_ok, 1'b1)
        // the byte on the check port belongs to the index one cycle back
        @(negedge clk_sys);
        p = id_idx;
        repeat (3)
        begin
            @(negedge clk_sys);
            `CHK(id_byte, fixb[p])
            p = id_idx;
        end
        // table entries, even then odd base, top entry 63 and entry 4 forced
        for (int j = 0; j < 16; j++)
        begin
            base = 20'($urandom) & ((j < 8) ? 20'hffffe : 20'hfffff);
            base[0] = (j >= 8);
            n = (j % 8 == 0) ? 63 : ((j % 8 == 1) ? 4 : $urandom % 64);
            lat = base[0] ? 6 : 4;
            run(ivm_pkg::IVM_SRC_TABLE, 6'(n), lat, base + 20'(4 * n),
                tab(base + 20'(4 * n)));
            // break redirect to entry zero when its top byte is ff
            wfix(11, (j % 2) ? 8'hff : 8'hfe);
            run(ivm_pkg::IVM_SRC_BREAK, 6'h00, (j % 2) ? 2 + lat : 9,
                (j % 2) ? base : 20'hfffe4,
                (j % 2) ? tab(base) : fixh(8));
        end
        // reserved reset nibble not all ones
        wfix(35, 8'ha0);
        run(ivm_pkg::IVM_SRC_RESET, 6'h00, 7, 20'hffffc, fixh(32));
        `CHK(rsv_ok, 1'b0)
        // global enable low: low entries refused, the rest still taken
        gie = 1'b0;
        @(negedge clk_sys);
        accept = 1'b1;
        src = ivm_pkg::IVM_SRC_TABLE;
        irq_number = 6'h05;
        #1;
        `CHK(blocked, 1'b1)
        `CHK(maskable, 1'b1)
        @(negedge clk_sys);
        accept = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk_sys);
            `CHK(done, 1'b0)
            `CHK(busy, 1'b0)
        end
        run(ivm_pkg::IVM_SRC_TABLE, 6'h20, lat, base + 20'h00080,
            tab(base + 20'h00080));
        // break top byte was left at ff, so it still goes to entry zero
        run(ivm_pkg::IVM_SRC_BREAK, 6'h00, 2 + lat, base, tab(base));
        gie = 1'b1;
        // shared and mode-switched sources, one cycle behind the inputs
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk_sys);
            sel = 2'($urandom);
            tw = 1'($urandom);
            pin = 3'($urandom);
            ser = 6'($urandom);
            mon = 3'($urandom);
            @(negedge clk_sys);
            `CHK(slots[0], sel[0] ? pin[2] : pin[0])
            `CHK(slots[1], sel[1] ? pin[2] : pin[1])
            `CHK(slots[2], tw ? ser[5] : ser[4])
            `CHK(slots[3], tw ? ser[2] : ser[0])
            `CHK(slots[4], tw ? ser[3] : ser[1])
            `CHK(slots[5], |mon)
        end
        end_sim();
    end
endmodule
